//--- hw/twmsr_core.sv
// The address map and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - START then read address enters master receive, write address master transmit.
// - Control write with flag, start, enable, no stop issues START when bus free.
// - After START is sent, flag sets with status 0x08.
// - After read address and acknowledge, flag sets with 0x40 or 0x48.
// - In 0x38 start 0 releases bus; start 1 sends repeated START at once.
// - In 0x40 and 0x50 next byte received, ACK per ack_enable.
// - In 0x48 start/stop select repeated START, STOP, or STOP then START.
// - In 0x58 start/stop select same actions as in 0x48.
// - Received byte stays readable in data register while flag set.
// - Flag, stop, enable write makes STOP; hardware then clears stop request.
// - After 0x10 read address keeps receive, write address switches to transmit.
// - Own address upper 7 bits match; LSB enables general call 0x00.
// - Own or general call address match: direction selects receive, or status 0xA8 with no data bits driven.
// - Lost arbitration then addressed for write reports 0x60 or 0x70.
// - ack_enable cleared mid-transfer gives NOT ACK after next received byte.
// - ack_enable low ignores own address; recognition resumes when set again.
// - Sleep with ack_enable set: match address, wake part, stretch SCL.
// - After such a wake the data register contents are not reliable.
// - Software clears flag by writing one; hardware sets it each bus step except STOP.
module twmsr_core
    import twmsr_pkg::*;
#(
    parameter int QUARTER = QUARTER_CYC
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_out,
    output logic             scl_oe_n_out,
    output logic             sda_out,
    output logic             sda_oe_n_out,
    input  wire logic        deep_sleep_in,
    output logic             wake_out,
    output logic             irq_out
);

    twmsr_pins_s  pin_meta, pin_sync, pin_prev;
    twmsr_state_e state;
    logic [7:0]   control, own_address, status, data, shreg;
    logic [3:0]   bit_cnt;
    logic [1:0]   phase;
    logic [15:0]  tick_cnt;
    logic         is_master, receiving, addr_phase, is_gc, hold_scl;
    logic         drive_sda, drive_scl, busy, ack_sent, read_ack;
    logic         pending_start, start_after_stop, slave_sends, acked_last;
    logic         answered;

    function automatic logic [7:0] be_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       en);
        be_merge = en ? new_v : old_v;
    endfunction : be_merge

    // Pin synchronisers and bus condition detection
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pin_meta <= '{scl: 1'b1, sda: 1'b1};
            pin_sync <= '{scl: 1'b1, sda: 1'b1};
            pin_prev <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            pin_meta <= '{scl: scl_in, sda: sda_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire scl_rise  = pin_sync.scl & ~pin_prev.scl;
    wire scl_fall  = ~pin_sync.scl & pin_prev.scl;
    wire bus_start = pin_sync.scl & pin_prev.scl & pin_prev.sda & ~pin_sync.sda;
    wire bus_stop  = pin_sync.scl & pin_prev.scl & ~pin_prev.sda & pin_sync.sda;
    wire tick      = (tick_cnt == 16'(QUARTER - 1));
    wire flag      = control[CTL_FLAG];
    wire enabled   = control[CTL_EN];
    wire ack_en    = control[CTL_ACK];

    // Register bus decode
    wire wr_ctl  = avs_write_in & (avs_address_in == ADDR_CONTROL)
                   & avs_byteenable_in[0];
    wire wr_dat  = avs_write_in & (avs_address_in == ADDR_DATA)
                   & avs_byteenable_in[0];
    wire wr_own  = avs_write_in & (avs_address_in == ADDR_OWNADDR);
    wire [7:0] wd = avs_writedata_in[7:0];
    wire clr_flag = wr_ctl & wd[CTL_FLAG];
    wire go       = enabled & ~flag;

    // Address match, general call match, ack_enable gate
    wire own_match = (shreg[7:1] == own_address[7:1]);
    wire gc_match  = own_address[0] & (shreg == GC_ADDRESS);
    wire addr_hit  = ack_en & (own_match | gc_match);

    // Reads take one wait cycle so data stand when it drops
    assign avs_waitrequest_out = avs_read_in & ~answered;
    assign irq_out  = flag & control[CTL_IRQEN];
    assign wake_out = deep_sleep_in & flag;
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n_out = ~(drive_scl | hold_scl);
    assign sda_oe_n_out = ~drive_sda;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in && !answered) begin
            case (avs_address_in)
                ADDR_DATA:    avs_readdata_out <= {24'h0, data};
                ADDR_CONTROL: avs_readdata_out <= {24'h0, control};
                ADDR_STATUS:  avs_readdata_out <= {24'h0, status};
                ADDR_OWNADDR: avs_readdata_out <= {24'h0, own_address};
                default:      avs_readdata_out <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tick_cnt <= 16'h0;
        end else if (tick || state == TWMSR_IDLE) begin
            tick_cnt <= 16'h0;
        end else begin
            tick_cnt <= tick_cnt + 16'h1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            own_address <= OWNADDR_RESET;
        end else if (wr_own) begin
            own_address <= be_merge(own_address, wd, avs_byteenable_in[0]);
        end
    end

    // Main protocol engine
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= TWMSR_IDLE;
            control <= CONTROL_RESET;
            status <= STATUS_IDLE;
            data <= 8'h0;
            shreg <= 8'h0;
            bit_cnt <= 4'h0;
            phase <= 2'h0;
            is_master <= 1'b0;
            receiving <= 1'b0;
            addr_phase <= 1'b0;
            is_gc <= 1'b0;
            hold_scl <= 1'b0;
            drive_sda <= 1'b0;
            drive_scl <= 1'b0;
            busy <= 1'b0;
            ack_sent <= 1'b0;
            read_ack <= 1'b0;
            pending_start <= 1'b0;
            start_after_stop <= 1'b0;
            slave_sends <= 1'b0;
            acked_last <= 1'b0;
            answered <= 1'b0;
        end else begin
            if (bus_start) busy <= 1'b1;
            if (bus_stop) busy <= 1'b0;
            answered <= avs_read_in & ~answered;
            if (wr_ctl) begin
                control[CTL_ACK]   <= wd[CTL_ACK];
                control[CTL_START] <= wd[CTL_START];
                control[CTL_STOP]  <= wd[CTL_STOP];
                control[CTL_EN]    <= wd[CTL_EN];
                control[CTL_IRQEN] <= wd[CTL_IRQEN];
                control[CTL_WCOL]  <= 1'b0;
                if (clr_flag) control[CTL_FLAG] <= 1'b0;
            end
            if (wr_dat) begin
                if (flag) data <= wd;
                else control[CTL_WCOL] <= 1'b1;
            end
            hold_scl <= hold_scl & flag & ~clr_flag;
            case (state)
                TWMSR_IDLE: begin
                    drive_sda <= 1'b0;
                    drive_scl <= 1'b0;
                    if (go && control[CTL_START] && !control[CTL_STOP]
                        && !busy) begin
                        state <= TWMSR_START;
                        phase <= 2'h0;
                    end else if (bus_start && enabled) begin
                        state <= TWMSR_BITS;
                        is_master <= 1'b0;
                        addr_phase <= 1'b1;
                        bit_cnt <= 4'h0;
                    end
                end
                TWMSR_START: if (tick) begin
                    phase <= phase + 2'h1;
                    if (phase == 2'h0) drive_sda <= 1'b1;
                    if (phase == 2'h2) begin
                        drive_scl <= 1'b1;
                        control[CTL_FLAG] <= 1'b1;
                        status <= is_master ? ST_RSTART : ST_START;
                        hold_scl <= 1'b1;
                        is_master <= 1'b1;
                        busy <= 1'b1;
                        addr_phase <= 1'b1;
                        control[CTL_START] <= 1'b0;
                        state <= TWMSR_HOLD;
                    end
                end
                TWMSR_HOLD: if (go) begin
                    bit_cnt <= 4'h0;
                    phase <= 2'h0;
                    if (is_master && control[CTL_STOP]) begin
                        start_after_stop <= control[CTL_START];
                        state <= TWMSR_STOP;
                    end else if (is_master && control[CTL_START]) begin
                        drive_scl <= 1'b0;
                        state <= TWMSR_START;
                    end else if (is_master && status == ST_ARB_LOST) begin
                        is_master <= 1'b0;
                        pending_start <= control[CTL_START];
                        drive_scl <= 1'b0;
                        state <= TWMSR_IDLE;
                    end else if (status == ST_SR_DNACK
                                 || status == ST_SR_GDNACK) begin
                        drive_scl <= 1'b0;
                        state <= TWMSR_IDLE;
                    end else begin
                        if (addr_phase && is_master) begin
                            receiving <= data[0];
                            shreg <= data;
                        end else if (is_master && !receiving) begin
                            shreg <= data;
                        end
                        acked_last <= ack_en;
                        state <= TWMSR_BITS;
                    end
                end
                TWMSR_BITS: begin
                    if (is_master && tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: begin
                                drive_sda <= ~(receiving && !addr_phase)
                                             & ~shreg[7];
                                drive_scl <= 1'b1;
                            end
                            2'h1: drive_scl <= 1'b0;
                            2'h2: begin
                                shreg <= {shreg[6:0], pin_sync.sda};
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                            2'h3: begin
                                drive_scl <= 1'b1;
                                if (bit_cnt == 4'h8) state <= TWMSR_ACK;
                            end
                            default: ;
                        endcase
                    end else if (!is_master && scl_rise) begin
                        shreg <= {shreg[6:0], pin_sync.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (!is_master && scl_fall
                                 && bit_cnt == 4'h8) begin
                        if (addr_phase) begin
                            is_gc <= gc_match;
                            ack_sent <= addr_hit & ~shreg[0];
                            slave_sends <= addr_hit & shreg[0];
                            drive_sda <= addr_hit;
                        end else begin
                            data <= deep_sleep_in ? data : shreg;
                            ack_sent <= acked_last;
                            drive_sda <= acked_last;
                        end
                        state <= TWMSR_ACK;
                    end
                    if (!is_master && bus_stop) state <= TWMSR_IDLE;
                end
                TWMSR_ACK: begin
                    if (is_master && tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: drive_sda <= receiving && !addr_phase
                                               && acked_last;
                            2'h1: drive_scl <= 1'b0;
                            2'h2: read_ack <= ~pin_sync.sda;
                            2'h3: begin
                                drive_scl <= 1'b1;
                                drive_sda <= 1'b0;
                                control[CTL_FLAG] <= 1'b1;
                                hold_scl <= 1'b1;
                                state <= TWMSR_HOLD;
                                if (receiving && !addr_phase) begin
                                    data <= shreg;
                                    status <= acked_last ? ST_MR_DACK
                                                         : ST_MR_DNACK;
                                end else if (receiving) begin
                                    status <= read_ack ? ST_MR_AACK
                                                       : ST_MR_ANACK;
                                end else begin
                                    status <= read_ack ? ST_MT_AACK
                                                       : ST_MT_ANACK;
                                end
                                addr_phase <= 1'b0;
                            end
                            default: ;
                        endcase
                        // Lost arbitration on the address byte
                        if (phase == 2'h2 && addr_phase && receiving
                            && pin_sync.sda && !shreg[0]) begin
                            status <= ST_ARB_LOST;
                        end
                    end else if (!is_master && scl_fall) begin
                        drive_sda <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (ack_sent || slave_sends) begin
                            control[CTL_FLAG] <= 1'b1;
                            hold_scl <= 1'b1;
                            state <= TWMSR_HOLD;
                            if (slave_sends) status <= pending_start
                                ? ST_SLV_TX_ARB : ST_SLV_TX;
                            else if (addr_phase) status <= is_gc
                                ? (pending_start ? ST_SR_GC_ARB : ST_SR_GC)
                                : (pending_start ? ST_SR_ARB
                                                 : ST_SR_ADDR);
                            else status <= is_gc ? ST_SR_GDACK : ST_SR_DACK;
                            addr_phase <= 1'b0;
                        end else if (!addr_phase) begin
                            control[CTL_FLAG] <= 1'b1;
                            hold_scl <= 1'b1;
                            status <= is_gc ? ST_SR_GDNACK : ST_SR_DNACK;
                            state <= TWMSR_HOLD;
                        end else begin
                            state <= TWMSR_IDLE;
                        end
                        pending_start <= 1'b0;
                    end
                end
                TWMSR_STOP: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: drive_sda <= 1'b1;
                        2'h1: drive_scl <= 1'b0;
                        2'h2: drive_sda <= 1'b0;
                        2'h3: begin
                            control[CTL_STOP] <= 1'b0;
                            is_master <= 1'b0;
                            receiving <= 1'b0;
                            busy <= 1'b0;
                            status <= STATUS_IDLE;
                            state <= start_after_stop ? TWMSR_START
                                                      : TWMSR_IDLE;
                        end
                        default: ;
                    endcase
                end
                default: state <= TWMSR_IDLE;
            endcase
        end
    end

endmodule : twmsr_core

//--- hw/twmsr_pkg.sv
package twmsr_pkg;

    // Register byte addresses on the Avalon-MM slave
    localparam logic [3:0] ADDR_DATA    = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;
    localparam logic [3:0] ADDR_OWNADDR = 4'hc;

    // Control register bit positions
    localparam int CTL_FLAG  = 7;
    localparam int CTL_ACK   = 6;
    localparam int CTL_START = 5;
    localparam int CTL_STOP  = 4;
    localparam int CTL_WCOL  = 3;
    localparam int CTL_EN    = 2;
    localparam int CTL_IRQEN = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OWNADDR_RESET = 8'hfe;
    localparam logic [7:0] STATUS_IDLE   = 8'hf8;

    // Status codes, prescaler bits zero
    localparam logic [7:0] ST_START      = 8'h08;
    localparam logic [7:0] ST_RSTART     = 8'h10;
    localparam logic [7:0] ST_MT_AACK    = 8'h18;
    localparam logic [7:0] ST_MT_ANACK   = 8'h20;
    localparam logic [7:0] ST_MT_DACK    = 8'h28;
    localparam logic [7:0] ST_MT_DNACK   = 8'h30;
    localparam logic [7:0] ST_ARB_LOST   = 8'h38;
    localparam logic [7:0] ST_MR_AACK    = 8'h40;
    localparam logic [7:0] ST_MR_ANACK   = 8'h48;
    localparam logic [7:0] ST_MR_DACK    = 8'h50;
    localparam logic [7:0] ST_MR_DNACK   = 8'h58;
    localparam logic [7:0] ST_SR_ADDR    = 8'h60;
    localparam logic [7:0] ST_SR_ARB     = 8'h68;
    localparam logic [7:0] ST_SR_GC      = 8'h70;
    localparam logic [7:0] ST_SR_GC_ARB  = 8'h78;
    localparam logic [7:0] ST_SR_DACK    = 8'h80;
    localparam logic [7:0] ST_SR_DNACK   = 8'h88;
    localparam logic [7:0] ST_SR_GDACK   = 8'h90;
    localparam logic [7:0] ST_SR_GDNACK  = 8'h98;
    localparam logic [7:0] ST_SLV_TX     = 8'ha8;
    localparam logic [7:0] ST_SLV_TX_ARB = 8'hb0;
    localparam logic [7:0] GC_ADDRESS    = 8'h00;

    // Quarter bit time of the bus clock generated as master
    localparam int SYS_CLK_MHZ   = 125;
    localparam int QUARTER_NS    = 1250;
    localparam int QUARTER_CYC   = (QUARTER_NS * SYS_CLK_MHZ) / 1000;

    typedef struct packed {
        logic scl;
        logic sda;
    } twmsr_pins_s;

    typedef enum logic [2:0] {
        TWMSR_IDLE,
        TWMSR_START,
        TWMSR_BITS,
        TWMSR_ACK,
        TWMSR_HOLD,
        TWMSR_STOP
    } twmsr_state_e;

endpackage : twmsr_pkg

//--- verif/twmsr_core_test.sv
`timescale 1ns/1ps
module twmsr_core_test
    import twmsr_pkg::*;
;
    logic        sys_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic        deep_sleep_in = 1'b0;
    logic        tb_scl = 1'b1;
    logic        tb_sda = 1'b1;
    logic        pt_sda, wreq, scl_oe_n, sda_oe_n, wake, a;
    logic [31:0] rdata;
    logic [7:0]  d;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    wire         scl_w = scl_oe_n & tb_scl;
    wire         sda_w = sda_oe_n & tb_sda & pt_sda;
    twmsr_core #(.QUARTER(4)) uut (.sys_clk_in, .reset_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .scl_in(scl_w), .sda_in(sda_w),
        .scl_out(), .scl_oe_n_out(scl_oe_n), .sda_out(),
        .sda_oe_n_out(sda_oe_n), .deep_sleep_in, .wake_out(wake), .irq_out());
    twmsr_partner u_slave (.scl_in(scl_w), .sda_in(sda_w), .sda_rel_out(pt_sda));
    initial forever #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] ad, input logic [7:0] v);
        @(posedge sys_clk_in);
        avs_address_in <= ad;
        avs_writedata_in <= {24'h0, v};
        avs_write_in <= 1'b1;
        do @(posedge sys_clk_in); while (wreq !== 1'b0);
        avs_write_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad);
        @(posedge sys_clk_in);
        avs_address_in <= ad;
        avs_read_in <= 1'b1;
        do @(posedge sys_clk_in); while (wreq !== 1'b0);
        d = rdata[7:0];
        avs_read_in <= 1'b0;
    endtask : rd
    // Status is compared with the prescaler bits masked off
    task automatic rc(input string s, input logic [3:0] ad, input logic [7:0] e);
        rd(ad);
        chk(s, e, ad == ADDR_STATUS ? d & 8'hf8 : d);
    endtask : rc
    task automatic wflag;
        do rd(ADDR_CONTROL); while (d[CTL_FLAG] !== 1'b1);
    endtask : wflag
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        wr(ADDR_CONTROL, c);
        wflag();
        rc("status", ADDR_STATUS, st);
    endtask : step
    task automatic stop_end;
        wr(ADDR_CONTROL, 8'h95);
        do rd(ADDR_CONTROL); while (d[CTL_STOP] !== 1'b0);
        rc("status", ADDR_STATUS, STATUS_IDLE);
        chk("bus", 8'h03, {6'h0, scl_w, sda_w});
    endtask : stop_end
    task automatic half;
        repeat (10) @(posedge sys_clk_in);
    endtask : half
    task automatic bm_bit(input logic b, output logic s);
        half();
        tb_sda <= b;
        half();
        tb_scl <= 1'b1;
        do @(posedge sys_clk_in); while (scl_w !== 1'b1);
        half();
        s = sda_w;
        tb_scl <= 1'b0;
    endtask : bm_bit
    task automatic bm_byte(input logic [7:0] v, output logic ack_n);
        tb_sda <= 1'b0;
        half();
        tb_scl <= 1'b0;
        for (int i = 7; i >= 0; i--) bm_bit(v[i], ack_n);
        bm_bit(1'b1, ack_n);
    endtask : bm_byte
    task automatic bm_stop;
        tb_sda <= 1'b0;
        half();
        tb_scl <= 1'b1;
        half();
        tb_sda <= 1'b1;
        half();
    endtask : bm_stop
    task automatic t_regs;
        rc("control", ADDR_CONTROL, CONTROL_RESET);
        rc("own", ADDR_OWNADDR, OWNADDR_RESET);
        rc("status", ADDR_STATUS, STATUS_IDLE);
        wr(4'h1, 8'hff);
        rc("unmapped", 4'h1, 8'h00);
        wr(ADDR_DATA, 8'h77);
        rc("collision", ADDR_CONTROL, 8'h08);
        rc("data", ADDR_DATA, 8'h00);
    endtask : t_regs
    task automatic t_mrx;
        step(8'ha5, ST_START);
        wr(ADDR_DATA, 8'ha1);
        step(8'hc5, ST_MR_AACK);
        step(8'hc5, ST_MR_DACK);
        rc("data", ADDR_DATA, 8'h3c);
        step(8'h85, ST_MR_DNACK);
        rc("data", ADDR_DATA, 8'h4d);
        stop_end();
    endtask : t_mrx
    task automatic t_nack;
        step(8'ha5, ST_START);
        wr(ADDR_DATA, 8'hb1);
        step(8'h85, ST_MR_ANACK);
        step(8'ha5, ST_RSTART);
        wr(ADDR_DATA, 8'ha1);
        step(8'h85, ST_MR_AACK);
        step(8'h85, ST_MR_DNACK);
        rc("data", ADDR_DATA, 8'h5e);
        stop_end();
    endtask : t_nack
    task automatic t_srx;
        wr(ADDR_OWNADDR, 8'h85);
        rc("own", ADDR_OWNADDR, 8'h85);
        wr(ADDR_CONTROL, 8'h04);
        bm_byte(8'h84, a);
        chk("addr nack", 8'h01, {7'h0, a});
        bm_stop();
        wr(ADDR_CONTROL, 8'h45);
        deep_sleep_in <= 1'b1;
        bm_byte(8'h84, a);
        chk("addr ack", 8'h00, {7'h0, a});
        wflag();
        rc("status", ADDR_STATUS, ST_SR_ADDR);
        chk("wake", 8'h01, {7'h0, wake});
        deep_sleep_in <= 1'b0;
        wr(ADDR_CONTROL, 8'hc5);
        bm_bit(1'b0, a);
        for (int i = 6; i >= 0; i--) bm_bit(i[0], a);
        bm_bit(1'b1, a);
        wflag();
        rc("status", ADDR_STATUS, ST_SR_DACK);
        rc("data", ADDR_DATA, 8'h2a);
        wr(ADDR_CONTROL, 8'hc5);
        bm_stop();
        bm_byte(8'h00, a);
        wflag();
        rc("status", ADDR_STATUS, ST_SR_GC);
        wr(ADDR_CONTROL, 8'hc5);
        bm_stop();
    endtask : t_srx
    initial begin
        repeat (10) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        t_regs();
        t_mrx();
        t_nack();
        t_srx();
        print_verdict();
    end
endmodule : twmsr_core_test

//--- verif/twmsr_partner.sv
`timescale 1ns/1ps
module twmsr_partner #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_rel_out
);
    logic [7:0] sh;
    logic [7:0] tx = 8'h3c;
    logic       nak;
    // Slave transmitter: bytes count up by 0x11 until the master sends NOT ACK
    initial begin
        sda_rel_out = 1'b1;
        forever begin
            @(negedge sda_in iff scl_in);
            repeat (8) begin
                @(posedge scl_in);
                sh = {sh[6:0], sda_in};
            end
            if (sh == {ADDR, 1'b1}) begin
                @(negedge scl_in) sda_rel_out = 1'b0;
                nak = 1'b0;
                while (!nak) begin
                    for (int i = 7; i >= 0; i--) begin
                        @(negedge scl_in) sda_rel_out = tx[i];
                    end
                    @(negedge scl_in) sda_rel_out = 1'b1;
                    @(posedge scl_in) nak = sda_in;
                    tx = tx + 8'h11;
                end
            end
        end
    end
endmodule : twmsr_partner

//--- verif/twmsr_properties.sv
`timescale 1ns/1ps
module twmsr_properties
    import twmsr_pkg::*;
#(
    parameter int QUARTER = QUARTER_CYC
) (
    input wire logic        sys_clk_in,
    input wire logic        reset_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        scl_oe_n_out,
    input wire logic        deep_sleep_in,
    input wire logic        wake_out,
    input wire logic        irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_own_wr;
        avs_write_in && avs_address_in == ADDR_OWNADDR && avs_byteenable_in[0];
    endsequence
    sequence s_own_rd;
        avs_read_in && avs_address_in == ADDR_OWNADDR;
    endsequence
    property p_own; s_own_wr ##2 s_own_rd
        |=> avs_readdata_out[7:0] == $past(avs_writedata_in[7:0], 3); endproperty
    a_own: assert property (p_own) else $error("own address lost");
    property p_hold; irq_out [*4] |-> !scl_oe_n_out; endproperty
    a_hold: assert property (p_hold) else $error("scl not held");
    property p_wake; deep_sleep_in && irq_out |-> wake_out; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_nowake; !deep_sleep_in |-> !wake_out; endproperty
    a_nowake: assert property (p_nowake) else $error("wake while awake");
    property p_wait; avs_waitrequest_out
        |-> avs_read_in ##1 !avs_waitrequest_out; endproperty
    a_wait: assert property (p_wait) else $error("read wait state wrong");
    property p_upper; avs_read_in |=> avs_readdata_out[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_unmap; avs_read_in && avs_address_in[1:0] != 2'h0
        |=> avs_readdata_out == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_keep; !avs_read_in |=> $stable(avs_readdata_out); endproperty
    a_keep: assert property (p_keep) else $error("read data moved");
endmodule : twmsr_properties

bind twmsr_core twmsr_properties #(.QUARTER(QUARTER)) u_props (
    .sys_clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .scl_oe_n_out, .deep_sleep_in, .wake_out, .irq_out);
